/* File: design/gauge_pkg.sv */
package gauge_pkg;

  localparam logic [6:0] slave_addr     = 7'h0b;
  localparam logic [7:0] crc_poly       = 8'h07;
  localparam logic [7:0] crc_init       = 8'h00;

  localparam logic [7:0] cmd_thermistor_b   = 8'h06;
  localparam logic [7:0] cmd_pack_adjust    = 8'h0b;
  localparam logic [7:0] cmd_temp_delay     = 8'h0c;
  localparam logic [7:0] cmd_profile_select = 8'h12;
  localparam logic [7:0] cmd_temp_source    = 8'h16;
  localparam logic [7:0] cmd_profile_code   = 8'h1a;
  localparam logic [7:0] cmd_term_rate      = 8'h1c;
  localparam logic [7:0] cmd_empty_voltage  = 8'h1d;
  localparam logic [7:0] cmd_empty_offset   = 8'h1e;

  localparam logic [15:0] rst_thermistor_b   = 16'h0d34;
  localparam logic [15:0] rst_pack_adjust    = 16'h0000;
  localparam logic [15:0] rst_temp_delay     = 16'h001e;
  localparam logic [15:0] rst_profile_select = 16'h0000;
  localparam logic [15:0] rst_temp_source    = 16'h0000;
  localparam logic [15:0] rst_term_rate      = 16'h0002;
  localparam logic [15:0] rst_empty_voltage  = 16'h0000;
  localparam logic [15:0] rst_empty_offset   = 16'h0000;

  localparam logic [15:0] max_profile_select = 16'h0004;
  localparam logic [15:0] min_term_rate      = 16'h0002;
  localparam logic [15:0] max_term_rate      = 16'h001e;
  localparam logic [15:0] empty_disabled     = 16'h0000;
  localparam logic [15:0] min_empty_voltage  = 16'h09c4;
  localparam logic [15:0] max_empty_voltage  = 16'h1388;
  localparam logic [15:0] max_empty_offset   = 16'h03e8;
  localparam logic [15:0] temp_src_bus       = 16'h0000;
  localparam logic [15:0] temp_src_thermistor = 16'h0001;

  // Time-out window is 12 s to 14 s; 13 s sits safely inside it.
  localparam longint bus_timeout_interval_ms = 13000;
  localparam longint core_clk_mhz            = 250;
  localparam longint timeout_cycles          = bus_timeout_interval_ms * 1000 * core_clk_mhz;

  typedef enum logic [2:0] {
    ph_idle,
    ph_addr,
    ph_cmd,
    ph_wlow,
    ph_whigh,
    ph_wcrc,
    ph_read,
    ph_ignore
  } phase_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  cmd;
    logic [15:0] data;
  } write_req_s;

endpackage

/* File: design/gauge_i2c_crc_register_port.sv */
`timescale 1ns/1ns
module gauge_i2c_crc_register_port #(
  parameter longint timeout_cycles = gauge_pkg::timeout_cycles
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        scl_link,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic [15:0] profile_code_in,
  output logic [15:0]      thermistor_b_constant,
  output logic [15:0]      pack_adjust_parameter,
  output logic [15:0]      temp_measure_delay,
  output logic [15:0]      profile_select,
  output logic [15:0]      temp_source_select,
  output logic [15:0]      termination_current_rate,
  output logic [15:0]      empty_cell_voltage,
  output logic [15:0]      empty_indicator_offset
);

  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ gauge_pkg::crc_poly) : (c << 1);
    end
    return c;
  endfunction

  // Link side: everything below up to the crossing runs on SCL itself.
  // START/STOP are seen as SDA edges while SCL is high, so they are sampled on
  // the core clock after synchronisation; STOP reaches the link as a reset level, START as the rs_flag level.
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  logic       start_seen;
  logic       stop_seen;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_link};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  always_comb begin
    start_seen = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
    stop_seen  = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
  end

  // Pending-START marker for the link. A START or repeated START comes at least
  // half a bit before the next SCL rise, so the flag is settled when the link
  // samples it there; the core clears it once it has seen that rise.
  logic       rs_flag;
  logic       frame_live;
  logic       timeout_abort;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_flag    <= 1'b0;
      frame_live <= 1'b0;
    end else if (start_seen) begin
      rs_flag    <= 1'b1;
      frame_live <= 1'b1;
    end else begin
      if (scl_sync[1] && !scl_q) begin
        rs_flag <= 1'b0;
      end
      if (stop_seen || timeout_abort) begin
        frame_live <= 1'b0;
      end
    end
  end

  // Link-side reset: low whenever the core says no frame is live.
  logic link_rst_n;
  assign link_rst_n = arst_n && frame_live;

  // Bit engine on SCL. Sampling on rising edge, driving on falling edge.
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  gauge_pkg::phase_e phase;
  logic       is_read;
  logic [7:0] cmd;
  logic [7:0] data_lo;
  logic [7:0] data_hi;
  logic [7:0] crc;
  logic [1:0] rd_idx;
  logic       ack_bit;
  logic [7:0] rd_byte;
  logic       nine_tog;
  logic       wr_tog;
  logic [7:0] wr_cmd_l;
  logic [15:0] wr_data_l;
  logic [15:0] rd_word;

  always_ff @(posedge scl_link or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      phase     <= gauge_pkg::ph_addr;
      is_read   <= 1'b0;
      cmd       <= 8'h00;
      data_lo   <= 8'h00;
      data_hi   <= 8'h00;
      crc       <= gauge_pkg::crc_init;
      rd_idx    <= 2'h0;
      nine_tog  <= 1'b0;
      wr_tog    <= 1'b0;
      wr_cmd_l  <= 8'h00;
      wr_data_l <= 16'h0000;
    end else begin
      if (rs_flag) begin
        // First bit after a (repeated) START: the setup rise before it was no bit.
        phase   <= gauge_pkg::ph_addr;
        shreg   <= {shreg[6:0], sda_in};
        bit_cnt <= 4'h1;
      end else if (bit_cnt < 4'h8) begin
        shreg   <= {shreg[6:0], sda_in};
        bit_cnt <= bit_cnt + 4'h1;
      end else begin
        bit_cnt  <= 4'h0;
        nine_tog <= ~nine_tog;
        case (phase)
          gauge_pkg::ph_addr: begin
            if (shreg[7:1] == gauge_pkg::slave_addr) begin
              crc     <= crc_step(crc, shreg);
              is_read <= shreg[0];
              phase   <= shreg[0] ? gauge_pkg::ph_read : gauge_pkg::ph_cmd;
              rd_idx  <= 2'h0;
            end else begin
              phase <= gauge_pkg::ph_ignore;
            end
          end
          gauge_pkg::ph_cmd: begin
            cmd   <= shreg;
            crc   <= crc_step(crc, shreg);
            phase <= gauge_pkg::ph_wlow;
          end
          gauge_pkg::ph_wlow: begin
            data_lo <= shreg;
            crc     <= crc_step(crc, shreg);
            phase   <= gauge_pkg::ph_whigh;
          end
          gauge_pkg::ph_whigh: begin
            data_hi <= shreg;
            crc     <= crc_step(crc, shreg);
            phase   <= gauge_pkg::ph_wcrc;
          end
          gauge_pkg::ph_wcrc: begin
            if (shreg == crc) begin
              wr_cmd_l  <= cmd;
              wr_data_l <= {data_hi, data_lo};
              wr_tog    <= ~wr_tog;
            end
            phase <= gauge_pkg::ph_ignore;
          end
          gauge_pkg::ph_read: begin
            if (rd_idx != 2'h3) begin
              crc <= crc_step(crc, rd_byte);
            end
            rd_idx <= (rd_idx == 2'h3) ? rd_idx : rd_idx + 2'h1;
            if (sda_in || rd_idx == 2'h2) begin
              phase <= gauge_pkg::ph_ignore;
            end
          end
          default: phase <= gauge_pkg::ph_ignore;
        endcase
      end
    end
  end

  always_comb begin
    case (rd_idx)
      2'h0:    rd_byte = rd_word[7:0];
      2'h1:    rd_byte = rd_word[15:8];
      default: rd_byte = crc;
    endcase
    ack_bit = (phase == gauge_pkg::ph_addr && shreg[7:1] == gauge_pkg::slave_addr)
           || phase == gauge_pkg::ph_cmd || phase == gauge_pkg::ph_wlow
           || phase == gauge_pkg::ph_whigh || phase == gauge_pkg::ph_wcrc;
  end

  // Drive SDA on the falling edge so data is stable across the high phase.
  logic sda_drv;
  always_ff @(negedge scl_link or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_drv <= 1'b0;
    end else if (bit_cnt == 4'h8) begin
      sda_drv <= ack_bit;
    end else if (phase == gauge_pkg::ph_read && bit_cnt < 4'h8) begin
      sda_drv <= !rd_byte[3'h7 - bit_cnt[2:0]];
    end else begin
      sda_drv <= 1'b0;
    end
  end

  // Core side: registers, write crossing and time-out.
  logic [2:0] wr_sync;
  logic [2:0] nine_sync;
  logic [1:0] drv_sync;
  logic       wr_event;
  logic       nine_event;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_sync   <= 3'h0;
      nine_sync <= 3'h0;
      drv_sync  <= 2'h0;
    end else begin
      wr_sync   <= {wr_sync[1:0], wr_tog};
      nine_sync <= {nine_sync[1:0], nine_tog};
      drv_sync  <= {drv_sync[0], sda_drv};
    end
  end

  always_comb begin
    wr_event   = wr_sync[2] ^ wr_sync[1];
    nine_event = nine_sync[2] ^ nine_sync[1];
  end

  // The written word is stable in the link registers well before the toggle
  // lands here, since SCL does not move again for at least a bus bit time.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      thermistor_b_constant    <= gauge_pkg::rst_thermistor_b;
      pack_adjust_parameter    <= gauge_pkg::rst_pack_adjust;
      temp_measure_delay       <= gauge_pkg::rst_temp_delay;
      profile_select           <= gauge_pkg::rst_profile_select;
      temp_source_select       <= gauge_pkg::rst_temp_source;
      termination_current_rate <= gauge_pkg::rst_term_rate;
      empty_cell_voltage       <= gauge_pkg::rst_empty_voltage;
      empty_indicator_offset   <= gauge_pkg::rst_empty_offset;
    end else if (wr_event) begin
      case (wr_cmd_l)
        gauge_pkg::cmd_thermistor_b: thermistor_b_constant <= wr_data_l;
        gauge_pkg::cmd_pack_adjust:  pack_adjust_parameter <= wr_data_l;
        gauge_pkg::cmd_temp_delay:   temp_measure_delay    <= wr_data_l;
        gauge_pkg::cmd_profile_select: begin
          if (wr_data_l <= gauge_pkg::max_profile_select) begin
            profile_select <= wr_data_l;
          end
        end
        gauge_pkg::cmd_temp_source: begin
          if (wr_data_l == gauge_pkg::temp_src_bus || wr_data_l == gauge_pkg::temp_src_thermistor) begin
            temp_source_select <= wr_data_l;
          end
        end
        gauge_pkg::cmd_term_rate: begin
          if (wr_data_l >= gauge_pkg::min_term_rate && wr_data_l <= gauge_pkg::max_term_rate) begin
            termination_current_rate <= wr_data_l;
          end
        end
        gauge_pkg::cmd_empty_voltage: begin
          if (wr_data_l == gauge_pkg::empty_disabled
              || (wr_data_l >= gauge_pkg::min_empty_voltage && wr_data_l <= gauge_pkg::max_empty_voltage)) begin
            empty_cell_voltage <= wr_data_l;
          end
        end
        gauge_pkg::cmd_empty_offset: begin
          if (wr_data_l <= gauge_pkg::max_empty_offset) begin
            empty_indicator_offset <= wr_data_l;
          end
        end
        default: ;
      endcase
    end
  end

  // Read word mux. The command is latched a full byte before the read data
  // is needed, so the link may read these core registers as quasi-static.
  always_comb begin
    case (cmd)
      gauge_pkg::cmd_thermistor_b:   rd_word = thermistor_b_constant;
      gauge_pkg::cmd_pack_adjust:    rd_word = pack_adjust_parameter;
      gauge_pkg::cmd_temp_delay:     rd_word = temp_measure_delay;
      gauge_pkg::cmd_profile_select: rd_word = profile_select;
      gauge_pkg::cmd_temp_source:    rd_word = temp_source_select;
      gauge_pkg::cmd_profile_code:   rd_word = profile_code_in;
      gauge_pkg::cmd_term_rate:      rd_word = termination_current_rate;
      gauge_pkg::cmd_empty_voltage:  rd_word = empty_cell_voltage;
      gauge_pkg::cmd_empty_offset:   rd_word = empty_indicator_offset;
      default:                       rd_word = 16'h0000;
    endcase
  end

  // Time-out counter runs while a frame is live and restarts at each ninth clock.
  logic [43:0] to_cnt;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      to_cnt        <= 44'h0;
      timeout_abort <= 1'b0;
    end else if (!frame_live || nine_event || start_seen) begin
      to_cnt        <= 44'h0;
      timeout_abort <= 1'b0;
    end else if (to_cnt >= 44'(timeout_cycles - 1)) begin
      to_cnt        <= 44'h0;
      timeout_abort <= 1'b1;
    end else begin
      to_cnt        <= to_cnt + 44'h1;
      timeout_abort <= 1'b0;
    end
  end

  // Bytes are served straight from registers, so no stretch is ever needed;
  // that trivially keeps any stretch far below the 0.5 ms limit.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= drv_sync[1] && frame_live;
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
    end
  end

endmodule

/* File: verif/gauge_port_assertions.sv */
`timescale 1ns/1ns
module gauge_port_checker #(
  parameter longint timeout_cycles = 2000
) (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        scl_link,
  input wire logic        sda_oe,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic [15:0] thermistor_b_constant,
  input wire logic [15:0] profile_select,
  input wire logic [15:0] temp_source_select,
  input wire logic [15:0] termination_current_rate,
  input wire logic [15:0] empty_cell_voltage,
  input wire logic [15:0] empty_indicator_offset
);
  logic   scl_q;
  longint since_rise;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Time since the last SCL rise never exceeds time since the ninth pulse, so a driven bit must end by the limit.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q      <= 1'b1;
      since_rise <= 0;
    end else begin
      scl_q      <= scl_link;
      since_rise <= (scl_link && !scl_q) ? 0 : since_rise + 1;
    end
  end
  AST_TIMEOUT_RELEASE: assert property (sda_oe |-> since_rise < timeout_cycles + 16)
    else $error("data line held past the bus time-out");
  AST_NO_STRETCH: assert property (!(scl_oe && !scl_out))
    else $error("clock line pulled low by the port");
  AST_HOLD_WHILE_HIGH: assert property ($changed(sda_oe) |-> !$past(scl_link))
    else $error("data drive changed while the clock was high");
  AST_RESET_VALUES: assert property ($rose(arst_n) |-> thermistor_b_constant == 16'h0d34
    && termination_current_rate == 16'h0002 && empty_cell_voltage == 16'h0000 && temp_source_select == 16'h0000)
    else $error("register not at its reset value");
  AST_PROFILE_RANGE: assert property (profile_select <= 16'h0004)
    else $error("profile select out of range");
  AST_TERM_RANGE: assert property (termination_current_rate inside {[16'h0002:16'h001e]})
    else $error("termination rate out of range");
  AST_EMPTY_RANGE: assert property (empty_cell_voltage == 16'h0000 || empty_cell_voltage inside {[16'h09c4:16'h1388]})
    else $error("empty voltage out of range");
  AST_OFFSET_RANGE: assert property (empty_indicator_offset <= 16'h03e8)
    else $error("indicator offset out of range");
  AST_SOURCE_RANGE: assert property (temp_source_select <= 16'h0001)
    else $error("temperature source out of range");
endmodule
bind gauge_i2c_crc_register_port gauge_port_checker #(.timeout_cycles(timeout_cycles)) chk_i (.*);

/* File: verif/i2c_host_model.sv */
`timescale 1ns/1ns
module i2c_host_model (
  output logic      scl,
  output logic      sda,
  input  wire logic scl_wire,
  input  wire logic sda_wire
);
  // Both lines idle released; SCL only toggles inside frames.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Data moves 8 ns after SCL falls so the port never sees it change with SCL.
  task automatic clk_bit(input logic b, output logic r);
    #8;
    sda = b;
    #24;
    scl = 1'b1;
    wait (scl_wire);
    r = sda_wire;
    #32;
    scl = 1'b0;
  endtask
  task automatic start();
    sda = 1'b1;
    #32;
    scl = 1'b1;
    wait (scl_wire);
    #200;
    sda = 1'b0;
    #200;
    scl = 1'b0;
  endtask
  task automatic stop();
    #8;
    sda = 1'b0;
    #24;
    scl = 1'b1;
    #200;
    sda = 1'b1;
    #200;
  endtask
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v[i], r);
    end
    clk_bit(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, v[i]);
    end
    clk_bit(nack, r);
  endtask
endmodule

/* File: verif/gauge_i2c_crc_register_port_tb_top.sv */
`timescale 1ns/1ns
module gauge_i2c_crc_register_port_tb_top;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        host_scl;
  logic        host_sda;
  logic        scl_w;
  logic        sda_w;
  logic        sda_out;
  logic        sda_oe;
  logic        scl_out;
  logic        scl_oe;
  logic [15:0] therm_b;
  logic [15:0] d;
  logic        a;
  int          compares = 0;
  int          miscompares = 0;
  int          cycles = 0;
  // Command, written value, value read back afterwards.
  logic [39:0] rows [19] = '{40'h06_1234_1234, 40'h0b_beef_beef, 40'h0c_0055_0055, 40'h12_0004_0004,
    40'h12_0005_0004, 40'h16_0001_0001, 40'h16_0002_0001, 40'h16_0000_0000, 40'h1c_001e_001e,
    40'h1c_001f_001e, 40'h1c_0001_001e, 40'h1d_09c4_09c4, 40'h1d_09c3_09c4, 40'h1d_1388_1388,
    40'h1d_0000_0000, 40'h1d_1389_0000, 40'h1e_03e8_03e8, 40'h1e_03e9_03e8, 40'h1a_1111_5a3c};
  logic [23:0] resets [8] = '{24'h06_0d34, 24'h0b_0000, 24'h0c_001e, 24'h12_0000,
    24'h16_0000, 24'h1c_0002, 24'h1d_0000, 24'h1e_0000};
  always #2 core_clk = ~core_clk;
  // Open-drain wires: any driver that is enabled pulls its line low.
  assign scl_w = host_scl & ~(scl_oe & ~scl_out);
  assign sda_w = host_sda & ~(sda_oe & ~sda_out);
  i2c_host_model host (.scl(host_scl), .sda(host_sda), .scl_wire(scl_w), .sda_wire(sda_w));
  gauge_i2c_crc_register_port #(.timeout_cycles(2000)) uut (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .scl_link(scl_w),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .profile_code_in(16'h5a3c),
    .thermistor_b_constant(therm_b),
    .pack_adjust_parameter(),
    .temp_measure_delay(),
    .profile_select(),
    .temp_source_select(),
    .termination_current_rate(),
    .empty_cell_voltage(),
    .empty_indicator_offset()
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] b [$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (b[i]) for (int k = 7; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i][k]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic word_write(input logic [7:0] cmd, input logic [15:0] v, input logic good, input int gap);
    logic [7:0] m [$];
    logic       ack;
    m = '{8'h16, cmd, v[7:0], v[15:8]};
    m.push_back(good ? crc8(m) : ~crc8(m));
    host.start();
    foreach (m[i]) begin
      host.wr_byte(m[i], ack);
      chk({15'h0000, ack}, 16'h0000);
      #(gap);
    end
    host.stop();
  endtask
  task automatic word_read(input logic [7:0] cmd, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] c;
    logic       ack;
    host.start();
    host.wr_byte(8'h16, ack);
    host.wr_byte(cmd, ack);
    host.start();
    host.wr_byte(8'h17, ack);
    chk({15'h0000, ack}, 16'h0000);
    host.rd_byte(1'b0, lo);
    host.rd_byte(1'b0, hi);
    host.rd_byte(1'b1, c);
    host.stop();
    v = {hi, lo};
    chk({8'h00, c}, {8'h00, crc8('{8'h16, cmd, 8'h17, lo, hi})});
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      $display("BAD %0t run did not finish", $time);
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk({8'h00, crc8('{8'h16, 8'h09, 8'h55, 8'haa})}, 16'h003b);
    foreach (resets[i]) begin
      word_read(resets[i][23:16], d);
      chk(d, resets[i][15:0]);
    end
    foreach (rows[i]) begin
      word_write(rows[i][39:32], rows[i][31:16], 1'b1, 0);
      word_read(rows[i][39:32], d);
      chk(d, rows[i][15:0]);
    end
    word_write(8'h06, 16'haaaa, 1'b0, 0);
    chk(therm_b, 16'h1234);
    // Each pause is under the limit but together they exceed it, so the count must restart per byte.
    word_write(8'h1c, 16'h0010, 1'b1, 6000);
    word_read(8'h1c, d);
    chk(d, 16'h0010);
    host.start();
    host.wr_byte(8'h18, a);
    host.stop();
    chk({15'h0000, a}, 16'h0001);
    host.start();
    host.wr_byte(8'h16, a);
    host.wr_byte(8'h1a, a);
    host.start();
    host.wr_byte(8'h17, a);
    #10000;
    chk({15'h0000, sda_oe}, 16'h0000);
    host.stop();
    word_read(8'h1a, d);
    chk(d, 16'h5a3c);
    finish_test();
  end
endmodule
